// ==== obml_loader.sv ====
// OTP boot mirror loader: copies OTP image into system RAM at boot
`timescale 1ns/10ps
`default_nettype none
//
// Overview of operation
// - Normal mode boot copies OTP into RAM.
// - After copy, hand off by reset or jump.
// - Copy runs on fast RC clock.
// - OTP read as 8K 32-bit words.
// - Vectors occupy first 64 words at zero.
// - Patch areas are header plus payload.
// - Development mode remaps zero, resets processor.
// - 42 kB system RAM is mirror destination.
// - Header length gives words to copy.
// - Header flag 0x00/0xAA gates debug port.
// - App valid only when marker matches.
module obml_loader #(
   parameter int OTP_AW = obml_pkg::OTP_AW,   // OTP word address width
   parameter int RAM_AW = obml_pkg::RAM_AW    // RAM word address width
) (
   // this clock is the fast_rc_oscillator during boot
   input  wire logic              clk_i,           // Fast RC clock
   input  wire logic              rst_n_i,         // Sync reset, low
   input  wire logic              boot_i,          // Boot/wake pulse
   input  wire logic              dev_mode_i,      // Development mode
   input  wire logic              dev_retram_i,    // Dev code in ret RAM
   input  wire logic              jump_handoff_i,  // 1 jump, 0 sw reset
   input  wire logic              main_xtal_ok_i,  // Crystal settled
   output logic                   otp_rd_o,        // OTP read strobe
   output logic [OTP_AW-1:0]      otp_addr_o,      // OTP word address
   input  wire logic [31:0]       otp_rdata_i,     // OTP data
   input  wire logic              otp_rvalid_i,    // OTP data valid
   output logic                   ram_we_o,        // RAM write strobe
   output logic [RAM_AW-1:0]      ram_addr_o,      // RAM word address
   output logic [31:0]            ram_wdata_o,     // RAM write data
   output logic                   cpu_hold_o,      // Processor held
   output logic                   cpu_reset_o,     // Processor reset pulse
   output logic                   cpu_jump_o,      // Jump-to-RAM pulse
   output logic [1:0]             remap_sel_o,     // Address zero target
   output logic                   dbg_port_en_o,   // Debug on pins
   output logic                   app_valid_o,     // OTP holds an app
   output logic                   use_rc_clk_o,    // Fast RC selected
   output logic                   busy_o           // Loader active
);

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   obml_pkg::obml_state_t   state_ff, nxt_state;
   logic [OTP_AW-1:0]       addr_ff, nxt_addr;
   logic [OTP_AW:0]         len_ff, nxt_len;
   logic [31:0]             data_ff, nxt_data;
   logic                    rd_ff, nxt_rd;
   logic                    we_ff, nxt_we;
   logic                    hold_ff, nxt_hold;
   logic                    rst_ff, nxt_rst;
   logic                    jmp_ff, nxt_jmp;
   logic [1:0]              map_ff, nxt_map;
   logic                    dbg_ff, nxt_dbg;
   logic                    app_ff, nxt_app;
   logic                    rc_ff, nxt_rc;

   // Header word indices derived from byte addresses
   localparam logic [OTP_AW-1:0] IDX_APP =
      OTP_AW'(obml_pkg::HDR_APP_FLAG >> 2);
   localparam logic [OTP_AW-1:0] IDX_LEN =
      OTP_AW'(obml_pkg::HDR_LENGTH >> 2);
   localparam logic [OTP_AW-1:0] IDX_DBG =
      OTP_AW'(obml_pkg::HDR_DBG_FLAG >> 2);
   // Clamp to the smaller of RAM and OTP: an oversized length must
   // neither run past RAM nor wrap the OTP index and loop forever
   localparam int                MAX_WORDS =
      (obml_pkg::RAM_WORDS < (1 << OTP_AW)) ? obml_pkg::RAM_WORDS
                                           : (1 << OTP_AW);
   localparam logic [OTP_AW:0]   MAX_LEN =
      (OTP_AW+1)'(MAX_WORDS);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_addr  = addr_ff;
      nxt_len   = len_ff;
      nxt_data  = data_ff;
      nxt_rd    = 1'b0;
      nxt_we    = 1'b0;
      nxt_hold  = hold_ff;
      nxt_rst   = 1'b0;
      nxt_jmp   = 1'b0;
      nxt_map   = map_ff;
      nxt_dbg   = dbg_ff;
      nxt_app   = app_ff;
      nxt_rc    = rc_ff;
      case (state_ff)
         obml_pkg::OBML_IDLE, obml_pkg::OBML_DONE: begin
            // leave RC clock once crystal settles
            if (state_ff == obml_pkg::OBML_DONE && main_xtal_ok_i) begin
               nxt_rc = 1'b0;
            end
            // Wake-up is taken at rest and after a handoff alike
            if (boot_i) begin
               nxt_hold = 1'b1;
               nxt_rc   = 1'b1;
               if (dev_mode_i) begin
                  nxt_map   = dev_retram_i ? obml_pkg::MAP_RETRAM
                                           : obml_pkg::MAP_SYSRAM;
                  nxt_state = obml_pkg::OBML_HANDOFF;
               end else begin
                  nxt_addr  = IDX_APP;
                  nxt_rd    = 1'b1;
                  nxt_state = obml_pkg::OBML_RD_FLAG;
               end
            end
         end
         obml_pkg::OBML_RD_FLAG: begin
            if (otp_rvalid_i) begin
               nxt_app = (otp_rdata_i == obml_pkg::APP_MARKER);
               if (otp_rdata_i == obml_pkg::APP_MARKER) begin
                  nxt_addr  = IDX_LEN;
                  nxt_rd    = 1'b1;
                  nxt_state = obml_pkg::OBML_RD_LEN;
               end else begin
                  // No image: stay in boot code, no copy
                  nxt_map   = obml_pkg::MAP_ROM;
                  nxt_state = obml_pkg::OBML_HANDOFF;
               end
            end
         end
         obml_pkg::OBML_RD_LEN: begin
            if (otp_rvalid_i) begin
               nxt_len   = (otp_rdata_i > 32'(MAX_LEN)) ? MAX_LEN
                           : otp_rdata_i[OTP_AW:0];
               nxt_addr  = IDX_DBG;
               nxt_rd    = 1'b1;
               nxt_state = obml_pkg::OBML_RD_DBG;
            end
         end
         obml_pkg::OBML_RD_DBG: begin
            if (otp_rvalid_i) begin
               nxt_dbg  = (otp_rdata_i[7:0] != obml_pkg::DBG_DISABLE);
               // start at word zero (vectors first)
               // vector table leads the copied image
               nxt_addr = '0;
               nxt_map  = obml_pkg::MAP_SYSRAM;
               if (len_ff == '0) begin
                  nxt_state = obml_pkg::OBML_HANDOFF;
               end else begin
                  nxt_rd    = 1'b1;
                  nxt_state = obml_pkg::OBML_COPY_RD;
               end
            end
         end
         obml_pkg::OBML_COPY_RD: begin
            // patch areas ride along as plain words
            if (otp_rvalid_i) begin
               nxt_data  = otp_rdata_i;
               nxt_we    = 1'b1;
               nxt_state = obml_pkg::OBML_COPY_WR;
            end
         end
         obml_pkg::OBML_COPY_WR: begin
            if ((OTP_AW+1)'(addr_ff) + 1'b1 >= len_ff) begin
               nxt_state = obml_pkg::OBML_HANDOFF;
            end else begin
               nxt_addr  = addr_ff + 1'b1;
               nxt_rd    = 1'b1;
               nxt_state = obml_pkg::OBML_COPY_RD;
            end
         end
         obml_pkg::OBML_HANDOFF: begin
            // jump only in normal mode with a matched app marker, else reset
            nxt_hold  = 1'b0;
            nxt_jmp   = jump_handoff_i & ~dev_mode_i & app_ff;
            nxt_rst   = ~(jump_handoff_i & ~dev_mode_i & app_ff);
            nxt_state = obml_pkg::OBML_DONE;
         end
         default: begin
            nxt_state = obml_pkg::OBML_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_ff <= obml_pkg::OBML_IDLE;
         addr_ff  <= '0;
         len_ff   <= '0;
         data_ff  <= '0;
         rd_ff    <= 1'b0;
         we_ff    <= 1'b0;
         hold_ff  <= 1'b1;
         rst_ff   <= 1'b0;
         jmp_ff   <= 1'b0;
         map_ff   <= obml_pkg::MAP_ROM;
         dbg_ff   <= 1'b1;
         app_ff   <= 1'b0;
         rc_ff    <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         addr_ff  <= nxt_addr;
         len_ff   <= nxt_len;
         data_ff  <= nxt_data;
         rd_ff    <= nxt_rd;
         we_ff    <= nxt_we;
         hold_ff  <= nxt_hold;
         rst_ff   <= nxt_rst;
         jmp_ff   <= nxt_jmp;
         map_ff   <= nxt_map;
         dbg_ff   <= nxt_dbg;
         app_ff   <= nxt_app;
         rc_ff    <= nxt_rc;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // word addressed OTP reads
   assign otp_rd_o      = rd_ff;
   assign otp_addr_o    = addr_ff;
   // RAM word offset mirrors OTP word index
   assign ram_we_o      = we_ff;
   assign ram_addr_o    = RAM_AW'(addr_ff);
   assign ram_wdata_o   = data_ff;
   assign cpu_hold_o    = hold_ff;
   assign cpu_reset_o   = rst_ff;
   assign cpu_jump_o    = jmp_ff;
   assign remap_sel_o   = map_ff;
   assign dbg_port_en_o = dbg_ff;
   assign app_valid_o   = app_ff;
   assign use_rc_clk_o  = rc_ff;
   assign busy_o        = (state_ff != obml_pkg::OBML_IDLE) &&
                          (state_ff != obml_pkg::OBML_DONE);
endmodule
`default_nettype wire

// ==== obml_loader_checker.sv ====
// Port timing checker for the boot mirror loader
`timescale 1ns/10ps
`default_nettype none
module obml_checker #(
   parameter int OTP_AW = 13   // OTP address width
) (
   input wire logic              clk_i,        // Clock
   input wire logic              rst_n_i,      // Reset
   input wire logic              boot_i,       // Boot
   input wire logic              dev_mode_i,   // Dev mode
   input wire logic              dev_retram_i, // Ret RAM
   input wire logic [31:0]       otp_rdata_i,  // OTP data
   input wire logic              otp_rvalid_i, // OTP valid
   input wire logic              otp_rd_o,     // Read
   input wire logic [OTP_AW-1:0] otp_addr_o,   // Address
   input wire logic              ram_we_o,     // Write
   input wire logic [31:0]       ram_wdata_o,  // Data
   input wire logic              cpu_hold_o,   // Hold
   input wire logic              cpu_reset_o,  // Reset
   input wire logic              cpu_jump_o,   // Jump
   input wire logic [1:0]        remap_sel_o,  // Remap
   input wire logic              use_rc_clk_o, // RC
   input wire logic              busy_o        // Busy
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Boot is taken only when the loader is free
   wire logic start = boot_i && !busy_o;
   property p_start;
      start && !dev_mode_i |=> otp_rd_o && otp_addr_o == 13'h1FC0;
   endproperty
   a_start: assert property (p_start) else $error("no marker read");
   property p_wdata;
      ram_we_o |-> $past(otp_rvalid_i) && ram_wdata_o == $past(otp_rdata_i);
   endproperty
   a_wdata: assert property (p_wdata) else $error("bad write");
   property p_hold;
      busy_o |-> cpu_hold_o && use_rc_clk_o;
   endproperty
   a_hold: assert property (p_hold) else $error("free while busy");
   property p_hand;
      cpu_reset_o || cpu_jump_o |-> !cpu_hold_o && !(cpu_reset_o && cpu_jump_o)
         ##1 !cpu_reset_o && !cpu_jump_o;
   endproperty
   a_hand: assert property (p_hand) else $error("bad handoff");
   property p_dmap;
      start && dev_mode_i |=> !otp_rd_o
         && remap_sel_o == ($past(dev_retram_i) ? 2'h2 : 2'h1)
         ##1 cpu_reset_o && !cpu_hold_o;
   endproperty
   a_dmap: assert property (p_dmap) else $error("bad remap");
   property p_rdwe;
      otp_rd_o |-> !ram_we_o;
   endproperty
   a_rdwe: assert property (p_rdwe) else $error("read with write");
   property p_rdbusy;
      otp_rd_o |-> busy_o && cpu_hold_o;
   endproperty
   a_rdbusy: assert property (p_rdbusy) else $error("idle read");
   property p_rdone;
      otp_rd_o |=> !otp_rd_o;
   endproperty
   a_rdone: assert property (p_rdone) else $error("long strobe");
endmodule
bind obml_loader obml_checker #(.OTP_AW(OTP_AW)) u_chk (.clk_i, .rst_n_i,
   .boot_i, .dev_mode_i, .dev_retram_i, .otp_rdata_i, .otp_rvalid_i,
   .otp_rd_o, .otp_addr_o, .ram_we_o, .ram_wdata_o, .cpu_hold_o,
   .cpu_reset_o, .cpu_jump_o, .remap_sel_o, .use_rc_clk_o, .busy_o);
`default_nettype wire

// ==== obml_loader_tb_top.sv ====
// Self-checking bench for the boot mirror loader
`timescale 1ns/10ps
`default_nettype none
module obml_loader_tb_top;
   logic clk_i, rst_n_i, boot_i, dev_mode_i, dev_retram_i, jump_handoff_i;
   logic main_xtal_ok_i, otp_rd_o, otp_rvalid_i, ram_we_o, cpu_hold_o;
   logic cpu_reset_o, cpu_jump_o, dbg_port_en_o, app_valid_o;
   logic use_rc_clk_o, busy_o;
   logic [12:0] otp_addr_o;
   logic [13:0] ram_addr_o;
   logic [31:0] otp_rdata_i, ram_wdata_o, marker, len;
   logic [7:0]  dbg;
   logic [1:0]  lat, remap_sel_o;
   int          err_count = 0, n_compared = 0, nw, nrst, njmp;
   obml_loader u_obml_loader (.clk_i, .rst_n_i, .boot_i, .dev_mode_i,
      .dev_retram_i, .jump_handoff_i, .main_xtal_ok_i, .otp_rd_o,
      .otp_addr_o, .otp_rdata_i, .otp_rvalid_i, .ram_we_o, .ram_addr_o,
      .ram_wdata_o, .cpu_hold_o, .cpu_reset_o, .cpu_jump_o, .remap_sel_o,
      .dbg_port_en_o, .app_valid_o, .use_rc_clk_o, .busy_o);
   obml_otp_model u_obml_otp_model (.clk_i(clk_i), .rd_i(otp_rd_o),
      .addr_i(otp_addr_o), .marker_i(marker), .len_i(len), .dbg_i(dbg),
      .lat_i(lat), .rdata_o(otp_rdata_i), .rvalid_o(otp_rvalid_i));
   function automatic logic [31:0] word(input logic [12:0] a);
      return {a ^ 13'h0A5A, 6'h33, a};
   endfunction
   task automatic chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One boot; a second boot pulse during the header reads must be ignored
   task automatic run(input logic d, r, j, input logic [31:0] m, l,
                      input logic [7:0] f, input logic x);
      logic ok;
      int   n;
      ok = m === obml_pkg::APP_MARKER && !d;
      @(negedge clk_i);
      {dev_mode_i, dev_retram_i, jump_handoff_i} = {d, r, j};
      {marker, len, dbg} = {m, l, f};
      lat = 2'($urandom_range(1, 3));
      main_xtal_ok_i = 1'($urandom);
      {nw, nrst, njmp} = {32'h0, 32'h0, 32'h0};
      boot_i = 1'b1;
      n = 0;
      while (nrst + njmp == 0 && n < 3000) begin
         @(negedge clk_i);
         n++;
         boot_i = x && ok && l > 7 && n == 6;
      end
      chk(32'(n < 3000), 32'h1);
      chk(nw, ok ? l : 32'h0);
      chk(njmp, 32'(ok && j));
      chk(nrst, 32'(!(ok && j)));
      chk(32'(cpu_hold_o), 32'h0);
      chk(32'(use_rc_clk_o), 32'(!main_xtal_ok_i));
      chk(32'(busy_o), 32'h0);
      if (!d) chk(32'(app_valid_o), 32'(m === 32'h1234A5A5));
      if (ok) chk(32'(dbg_port_en_o), 32'(f != 8'hAA));
      if (d) chk(32'(remap_sel_o), r ? 32'h2 : 32'h1);
      else if (!ok) chk(32'(remap_sel_o), 32'h0);
      else chk(32'(remap_sel_o), 32'(obml_pkg::MAP_SYSRAM));
   endtask
   // Mirror writes land ascending from index zero
   always @(posedge clk_i) if (rst_n_i) begin
      if (ram_we_o) begin
         chk(32'(ram_addr_o), nw);
         chk(ram_wdata_o, word(nw[12:0]));
         nw++;
      end
      if (cpu_reset_o) nrst++;
      if (cpu_jump_o) njmp++;
   end
   always #2 clk_i = ~clk_i;
   initial begin
      #400000;
      err_count++;
      finish_test();
   end
   initial begin
      {clk_i, rst_n_i, boot_i, dev_mode_i, dev_retram_i} = 5'h00;
      {jump_handoff_i, main_xtal_ok_i, marker, len, dbg, lat} = 76'h1;
      void'($urandom(92969));
      repeat (16) @(negedge clk_i);
      // Reset values: processor held, RC clock on, debug on
      chk(32'({cpu_hold_o, use_rc_clk_o, dbg_port_en_o}), 32'h7);
      chk(32'({app_valid_o, busy_o, remap_sel_o}), 32'h0);
      rst_n_i = 1'b1;
      run(1'b1, 1'b0, 1'b0, 32'h0, 32'h8, 8'h00, 1'b0);
      run(1'b1, 1'b1, 1'b1, 32'h0, 32'h8, 8'h00, 1'b0);
      run(1'b0, 1'b0, 1'b1, 32'hA5A51234, 32'h8, 8'h00, 1'b0);
      run(1'b0, 1'b0, 1'b1, 32'h1234A5A5, 32'h0, 8'hAA, 1'b0);
      run(1'b0, 1'b0, 1'b0, 32'h1234A5A5, 32'h40, 8'h00, 1'b1);
      for (int i = 0; i < 30; i++) begin
         run(1'($urandom % 5 == 0), 1'($urandom), 1'($urandom),
             ($urandom % 6 == 0) ? $urandom : 32'h1234A5A5,
             $urandom_range(0, 80), ($urandom % 2) ? 8'hAA : 8'($urandom),
             1'b1);
      end
      finish_test();
   end
endmodule
`default_nettype wire

// ==== obml_otp_model.sv ====
// Behavioural OTP array answering the loader's reads
`timescale 1ns/10ps
`default_nettype none
module obml_otp_model (
   input  wire logic        clk_i,     // Clock
   input  wire logic        rd_i,      // Read strobe
   input  wire logic [12:0] addr_i,    // Word index
   input  wire logic [31:0] marker_i,  // App flag word
   input  wire logic [31:0] len_i,     // Length word
   input  wire logic [7:0]  dbg_i,     // Debug flag byte
   input  wire logic [1:0]  lat_i,     // Latency, 1 to 3
   output logic [31:0]      rdata_o,   // Read data
   output logic             rvalid_o   // Read valid
);
   logic [1:0]  cnt_ff = 2'h0;
   logic [12:0] a_ff;
   function automatic logic [31:0] word(input logic [12:0] a);
      // calibration words are the programmer's; none read
      if (a == 13'h1FC0) return marker_i;
      if (a == 13'h1FFE) return len_i;
      if (a == 13'h1FFF) return {4{dbg_i}};
      return {a ^ 13'h0A5A, 6'h33, a};
   endfunction
   initial begin
      rdata_o = 32'h0;
      rvalid_o = 1'b0;
   end
   // Idle bus flips each cycle so stale data never looks valid
   always @(posedge clk_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (cnt_ff == 2'h1) begin
         rvalid_o <= 1'b1;
         rdata_o <= word(a_ff);
      end
      if (cnt_ff != 2'h0) cnt_ff <= cnt_ff - 2'h1;
      if (rd_i) begin
         cnt_ff <= lat_i;
         a_ff <= addr_i;
      end
   end
endmodule
`default_nettype wire

// ==== obml_pkg.sv ====
// Package of constants for the OTP boot mirror loader
package obml_pkg;
   // OTP geometry: 8K words of 32 bits
   localparam int          OTP_WORDS     = 8192;
   localparam int          OTP_AW        = 13;
   localparam int          DATA_W        = 32;
   // System RAM: 42 kB as 32-bit words
   localparam int          RAM_BYTES     = 43008;
   localparam int          RAM_WORDS     = RAM_BYTES / 4;
   localparam int          RAM_AW        = 14;
   // Vector table size in words
   localparam int          VEC_WORDS     = 64;
   // Header byte addresses, converted to word indices
   localparam logic [15:0] HDR_APP_FLAG  = 16'h7F00;
   localparam logic [15:0] HDR_LENGTH    = 16'h7FF8;
   localparam logic [15:0] HDR_DBG_FLAG  = 16'h7FFC;
   localparam logic [31:0] APP_MARKER    = 32'h1234A5A5;
   localparam logic [7:0]  DBG_ENABLE    = 8'h00;
   localparam logic [7:0]  DBG_DISABLE   = 8'hAA;
   // Remap target selection
   localparam logic [1:0]  MAP_ROM       = 2'h0;
   localparam logic [1:0]  MAP_SYSRAM    = 2'h1;
   localparam logic [1:0]  MAP_RETRAM   = 2'h2;
   typedef enum logic [3:0] {
      OBML_IDLE, OBML_RD_FLAG, OBML_RD_LEN, OBML_RD_DBG,
      OBML_COPY_RD, OBML_COPY_WR, OBML_HANDOFF, OBML_DONE
   } obml_state_t;
endpackage
